// >>> smc_consts.svh
// constants of the sleep mode controller: bit positions, codes and cycle counts
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// ***************************************************************
// sleep control register layout
// ***************************************************************
`define SMC_ARM_BIT       0
`define SMC_SEL_LSB       1
`define SMC_SEL_MSB       2
`define SMC_SLEEP_RST     8'h00

// ***************************************************************
// core control register layout
// ***************************************************************
`define SMC_BROWNOUT_SLEEP_OFF_BIT      6
`define SMC_UNLOCK_BIT    5
`define SMC_CORE_RST      8'h00

// ***************************************************************
// cycle counts
// ***************************************************************
`define SMC_UNLOCK_CYC    3'h4
`define SMC_BROWNOUT_SLEEP_OFF_LIFE     3'h6
`define SMC_BROWNOUT_SLEEP_OFF_ACT_HI   3'h3
`define SMC_HOLD_LAST     16'h0003
`define SMC_IDLE_STARTUP  16'h0000

`endif

// >>> smc_pkg.sv
// types shared by the sleep mode controller modules
package smc_pkg;

  // ***************************************************************
  // states and modes
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,                    // cpu executing
    ST_SLEEP = 4'h2,                    // clocks gated per mode
    ST_WAKE  = 4'h4,                    // start-up delay running
    ST_HOLD  = 4'h8                     // extra cpu hold before handler
  } smc_state_t;

  typedef enum logic [1:0] {
    MODE_IDLE  = 2'h0,
    MODE_ADCNR = 2'h1,
    MODE_PDOWN = 2'h2,
    MODE_RSVD  = 2'h3
  } smc_mode_t;

  // ***************************************************************
  // carriers
  // ***************************************************************
  typedef struct packed {
    logic any_irq;                      // any enabled interrupt pending
    logic ext_a;                        // ext_irq_a request
    logic ext_b;                        // ext_irq_b request
    logic ext_a_level;                  // ext_irq_a set for level sensing
    logic ext_b_level;                  // ext_irq_b set for level sensing
    logic pin_change;                   // pin change interrupt
    logic twi_match;                    // two_wire_port address match
    logic ee_ready;                     // eeprom ready interrupt
    logic adc_done;                     // conversion complete interrupt
    logic wdt_irq;                      // watchdog_unit interrupt
  } smc_wake_t;

  typedef struct packed {
    logic cpu;                          // cpu_clock_domain enable
    logic flash;                        // flash_clock_domain enable
    logic io;                           // io_clock_domain enable
    logic adc;                          // converter_clock_domain enable
    logic osc;                          // main oscillator enable
  } smc_clk_t;

endpackage : smc_pkg

// >>> smc_brownout_sleep_off_seq.sv
// timed unlock sequence and lifetime of the brown-out sleep-off bit
`timescale 1ns/100ps
`include "smc_consts.svh"
module smc_brownout_sleep_off_seq import smc_pkg::*; (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       core_wr,         // write strobe for core_control_reg
  input  wire logic [7:0] core_wdata,      // write data
  output logic            brownout_sleep_off_bit,        // brownout_sleep_off as read back
  output logic            unlock_bit,      // brownout_sleep_unlock as read back
  output logic            brownout_sleep_off_active      // a sleep now may turn the detector off
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [2:0] unlock_q, unlock_d;          // remaining unlock window
  logic [2:0] life_q, life_d;              // remaining life of the sleep-off bit
  logic       w_off, w_unl;

  // ***************************************************************
  // next state
  // ***************************************************************
  // a first write with both bits opens the window; the second must drop the
  // unlock bit or nothing happens, so stray writes cannot disarm the detector
  always_comb begin
    w_off    = core_wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT];
    w_unl    = core_wdata[`SMC_UNLOCK_BIT];
    unlock_d = (unlock_q != '0) ? unlock_q - 3'h1 : unlock_q;
    life_d   = (life_q != '0) ? life_q - 3'h1 : life_q;
    if (core_wr && w_off && w_unl) begin                 // open window
      unlock_d = `SMC_UNLOCK_CYC;                        // R17
    end else if (core_wr && w_off && !w_unl && unlock_q != '0) begin
      unlock_d = '0;                                     // R17
      life_d   = `SMC_BROWNOUT_SLEEP_OFF_LIFE;                         // R18
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      unlock_q <= '0;
      life_q   <= '0;
    end else begin
      unlock_q <= unlock_d;
      life_q   <= life_d;
    end
  end

  // bit set for six cycles; usable for sleep in its last three
  assign brownout_sleep_off_bit    = (life_q != '0);
  assign unlock_bit  = (unlock_q != '0);
  assign brownout_sleep_off_active = (life_q != '0) && (life_q <= `SMC_BROWNOUT_SLEEP_OFF_ACT_HI);  // R18

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_brownout_sleep_off_life_span: assert property ($rose(brownout_sleep_off_bit) |-> brownout_sleep_off_bit[*6] ##1 !brownout_sleep_off_bit) // R18
    else $error("sleep-off bit did not live six cycles");
  chk_brownout_sleep_off_act_delay: assert property ($rose(brownout_sleep_off_bit) |-> !brownout_sleep_off_active[*3] ##1 brownout_sleep_off_active[*3]) // R18
    else $error("sleep-off bit not active three cycles after set");
  chk_unlock_refused: assert property
    (core_wr && core_wdata[`SMC_BROWNOUT_SLEEP_OFF_BIT] && !core_wdata[`SMC_UNLOCK_BIT] && !unlock_bit
     && !brownout_sleep_off_bit |=> !brownout_sleep_off_bit) // R17
    else $error("sleep-off bit set without unlock");

endmodule : smc_brownout_sleep_off_seq

// >>> smc_top.sv
// sleep mode controller: mode entry, clock gating, wake filtering and delays
// How it works
// [R1] sleep needs arm bit plus sleep instruction
// [R2] mode 00 idle: stop cpu and flash
// [R3] mode 01: also stop io clock
// [R4] mode 10: stop oscillator and all clocks
// [R5] interrupt wake holds cpu four extra cycles
// [R6] register file and sram kept across sleep
// [R7] reset during sleep restarts at reset vector
// [R8] idle wakes on any enabled interrupt
// [R9] noise reduction wakes on listed events only
// [R10] power-down wakes on listed events only
// [R11] deep modes: external irqs wake only level-sensed
// [R12] enabled adc converts on idle/noise entry
// [R13] power-down wake waits oscillator start-up time
// [R14] detector off in sleep, on at wake; code turns it off only in power-down with the sleep-off bit active
// [R15] detector off means full reset wake time
// [R16] sleep-off control is core register bit 6
// [R17] unlock write then set within four cycles
// [R18] sleep-off active after three, clears three later
// [R19] deep sleep disables unneeded input buffers
// [R20] adc stays on; re-enable means extended conversion
// [R21] comparator off in power-down; reference may stay
// [R22] reference on while detector, comparator, adc need
// [R23] enabled watchdog runs in every mode
// [R24] debug fuse keeps main clock running
// [R25] reserved mode code causes no sleep
`timescale 1ns/100ps
`include "smc_consts.svh"
module smc_top import smc_pkg::*; (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sleep_wr,         // write strobe, sleep_control_reg
  input  wire logic [7:0]  sleep_wdata,      // write data, sleep_control_reg
  input  wire logic        core_wr,          // write strobe, core_control_reg
  input  wire logic [7:0]  core_wdata,       // write data, core_control_reg
  input  wire logic        sleep_instr,      // one-cycle pulse: sleep executed
  input  wire smc_wake_t   wake_ev,          // wake sources
  input  wire logic        reset_event,      // any reset source active
  input  wire logic [15:0] startup_cycles,   // decoded clock_source_fuse start-up
  input  wire logic [15:0] reset_cycles,     // decoded reset time-out
  input  wire logic        bod_fuse,         // brownout_level_fuse enables detector
  input  wire logic        debug_fuse,       // onchip_debug_fuse
  input  wire logic        adc_enable,       // converter enabled by software
  input  wire logic        comp_on,          // comparator_off_bit clear
  input  wire logic        comp_uses_ref,    // comparator takes internal reference
  input  wire logic        wdt_enable,       // watchdog_unit enabled
  input  wire logic        wake_pin_armed,   // some pin must detect a wake condition
  output smc_clk_t         gate_q,           // clock domain enables
  output logic             cpu_hold_q,       // cpu halted
  output logic             retain_q,         // register file and sram frozen
  output logic             irq_resume_q,     // pulse: cpu enters handler
  output logic             reset_vector_q,   // pulse: cpu restarts at reset vector
  output logic             adc_start_q,      // pulse: start a conversion
  output logic             adc_power_q,      // converter powered
  output logic             adc_extended_q,   // next conversion is extended
  output logic             bod_en_q,         // brownout_detector powered
  output logic             comp_en_q,        // comparator powered
  output logic             vref_en_q,        // internal reference powered
  output logic             wdt_run_q,        // watchdog clock allowed
  output logic             in_buf_en_q,      // general digital input buffers
  output logic             wake_buf_en_q,    // buffers of wake pins
  output logic [7:0]       sleep_ctl_rd_q,   // sleep_control_reg read value
  output logic [7:0]       core_ctl_rd_q     // core_control_reg read value
);

  // ***************************************************************
  // wake filter
  // ***************************************************************
  // edge-sensed external requests are dropped in the deep modes because
  // no clock exists there to detect an edge
  function automatic logic smc_wake_ok(smc_mode_t m, smc_wake_t w);
    logic lvl;
    lvl = (w.ext_a && w.ext_a_level) || (w.ext_b && w.ext_b_level)   // R11
          || w.pin_change || w.twi_match || w.wdt_irq;
    case (m)
      MODE_IDLE:  smc_wake_ok = w.any_irq || w.ext_a || w.ext_b || lvl
                                || w.ee_ready || w.adc_done;        // R8
      MODE_ADCNR: smc_wake_ok = lvl || w.adc_done || w.ee_ready;    // R9
      MODE_PDOWN: smc_wake_ok = lvl;                                // R10
      default:    smc_wake_ok = 1'b0;
    endcase
  endfunction : smc_wake_ok

  // ***************************************************************
  // signals
  // ***************************************************************
  smc_state_t  state_q, state_d;         // sequencer state
  smc_mode_t   mode_q, mode_d;           // mode captured at entry
  logic [15:0] cnt_q, cnt_d;             // start-up and hold counter
  logic        rst_kind_q, rst_kind_d;   // wake caused by reset
  logic        bod_off_q, bod_off_d;     // detector switched off for this sleep
  logic [7:0]  sctl_q, sctl_d;           // sleep_control_reg contents
  logic        adc_prev_q;               // adc_enable one cycle ago
  logic        brownout_sleep_off_bit, unlock_bit, brownout_sleep_off_active;
  smc_mode_t   sel;                      // mode field as written
  logic        deep;                     // io and adc clocks both stopped
  smc_clk_t    gate_d;
  logic        irq_res_d, rst_vec_d, adc_start_d, adc_ext_d, bod_en_d;

  // ***************************************************************
  // brown-out sleep-off sequence
  // ***************************************************************
  smc_brownout_sleep_off_seq u_brownout_sleep_off (
    .clk         (clk),
    .resetn      (resetn),
    .core_wr     (core_wr),
    .core_wdata  (core_wdata),
    .brownout_sleep_off_bit    (brownout_sleep_off_bit),                                          // R16
    .unlock_bit  (unlock_bit),
    .brownout_sleep_off_active (brownout_sleep_off_active)
  );

  // ***************************************************************
  // sequencer next state
  // ***************************************************************
  always_comb begin
    sel         = smc_mode_t'(sctl_q[`SMC_SEL_MSB:`SMC_SEL_LSB]);
    sctl_d      = sctl_q;
    state_d     = state_q;
    mode_d      = mode_q;
    cnt_d       = cnt_q;
    rst_kind_d  = rst_kind_q;
    bod_off_d   = bod_off_q;
    irq_res_d   = 1'b0;
    rst_vec_d   = 1'b0;
    adc_start_d = 1'b0;
    // only the arm bit and mode field exist; other bits read as zero
    if (sleep_wr) begin
      sctl_d = `SMC_SLEEP_RST;
      sctl_d[`SMC_ARM_BIT] = sleep_wdata[`SMC_ARM_BIT];
      sctl_d[`SMC_SEL_MSB:`SMC_SEL_LSB] = sleep_wdata[`SMC_SEL_MSB:`SMC_SEL_LSB];
    end
    case (state_q)
      ST_RUN: begin
        // the reserved code is ignored rather than gating clocks oddly
        if (sleep_instr && sctl_q[`SMC_ARM_BIT] && sel != MODE_RSVD) begin // R1 R25
          state_d     = ST_SLEEP;
          mode_d      = sel;
          bod_off_d   = brownout_sleep_off_active && sel == MODE_PDOWN;                  // R14
          adc_start_d = adc_enable && sel != MODE_PDOWN;                   // R12
        end
      end
      ST_SLEEP: begin
        if (reset_event) begin                                             // R7
          state_d    = ST_WAKE;
          rst_kind_d = 1'b1;
          cnt_d      = reset_cycles;
        end else if (smc_wake_ok(mode_q, wake_ev)) begin
          state_d    = ST_WAKE;
          rst_kind_d = 1'b0;
          if (bod_off_q) begin
            cnt_d = reset_cycles;                                          // R15
          end else if (mode_q == MODE_PDOWN) begin
            cnt_d = startup_cycles;                                        // R13
          end else begin
            cnt_d = `SMC_IDLE_STARTUP;
          end
        end
      end
      ST_WAKE: begin
        // detector back on from here; counter runs down the start-up time
        bod_off_d = 1'b0;                                                  // R14
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 16'h0001;
        end else if (rst_kind_q) begin
          state_d   = ST_RUN;
          rst_vec_d = 1'b1;                                                // R7
        end else begin
          state_d = ST_HOLD;
          cnt_d   = `SMC_HOLD_LAST;                                        // R5
        end
      end
      ST_HOLD: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 16'h0001;
        end else begin
          state_d   = ST_RUN;
          irq_res_d = 1'b1;                                                // R5
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ***************************************************************
  // outputs next value, derived from the next state
  // ***************************************************************
  // deriving from state_d keeps gates aligned with state_q after the edge
  always_comb begin
    deep        = (state_d == ST_SLEEP) && (mode_d == MODE_PDOWN);
    gate_d.cpu   = (state_d == ST_RUN);                                    // R2
    gate_d.flash = (state_d == ST_RUN);                                    // R2
    gate_d.io    = !((state_d == ST_SLEEP) && mode_d != MODE_IDLE);        // R3
    gate_d.adc   = !deep;                                                  // R4
    gate_d.osc   = !deep || debug_fuse;                                    // R4 R24
    bod_en_d    = bod_fuse && !((state_d == ST_SLEEP) && bod_off_d);       // R14
    // set wins over the clear when both come in one cycle
    adc_ext_d   = adc_extended_q;
    if (wake_ev.adc_done) begin
      adc_ext_d = 1'b0;
    end
    if (adc_enable && !adc_prev_q) begin
      adc_ext_d = 1'b1;                                                    // R20
    end
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q        <= ST_RUN;
      mode_q         <= MODE_IDLE;
      cnt_q          <= '0;
      rst_kind_q     <= 1'b0;
      bod_off_q      <= 1'b0;
      sctl_q         <= `SMC_SLEEP_RST;
      adc_prev_q     <= 1'b0;
      gate_q         <= '1;
      cpu_hold_q     <= 1'b0;
      retain_q       <= 1'b0;
      irq_resume_q   <= 1'b0;
      reset_vector_q <= 1'b0;
      adc_start_q    <= 1'b0;
      adc_power_q    <= 1'b0;
      adc_extended_q <= 1'b0;
      bod_en_q       <= 1'b0;
      comp_en_q      <= 1'b0;
      vref_en_q      <= 1'b0;
      wdt_run_q      <= 1'b0;
      in_buf_en_q    <= 1'b1;
      wake_buf_en_q  <= 1'b1;
      sleep_ctl_rd_q <= `SMC_SLEEP_RST;
      core_ctl_rd_q  <= `SMC_CORE_RST;
    end else begin
      state_q        <= state_d;
      mode_q         <= mode_d;
      cnt_q          <= cnt_d;
      rst_kind_q     <= rst_kind_d;
      bod_off_q      <= bod_off_d;
      sctl_q         <= sctl_d;
      adc_prev_q     <= adc_enable;
      gate_q         <= gate_d;
      cpu_hold_q     <= (state_d != ST_RUN);
      retain_q       <= (state_d != ST_RUN);                               // R6
      irq_resume_q   <= irq_res_d;
      reset_vector_q <= rst_vec_d;
      adc_start_q    <= adc_start_d;
      adc_power_q    <= adc_enable;                                        // R20
      adc_extended_q <= adc_ext_d;
      bod_en_q       <= bod_en_d;
      comp_en_q      <= comp_on && !((state_d == ST_SLEEP) && mode_d == MODE_PDOWN); // R21
      vref_en_q      <= bod_en_d || adc_enable || (comp_on && comp_uses_ref); // R21 R22
      wdt_run_q      <= wdt_enable;                                        // R23
      in_buf_en_q    <= !deep;                                             // R19
      wake_buf_en_q  <= !deep || wake_pin_armed;                           // R19
      sleep_ctl_rd_q <= sctl_q;
      core_ctl_rd_q  <= {1'b0, brownout_sleep_off_bit, unlock_bit, 5'h00};               // R16
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_sleep_needs_arm: assert property
    (state_q == ST_RUN && sleep_instr && (!sctl_q[`SMC_ARM_BIT] || sel == MODE_RSVD)
     |=> state_q == ST_RUN) // R1 R25
    else $error("sleep entered without arm bit or with reserved mode");
  chk_idle_gates: assert property
    (state_q == ST_SLEEP && mode_q == MODE_IDLE |-> !gate_q.cpu && !gate_q.flash
     && gate_q.io && gate_q.adc && gate_q.osc) // R2
    else $error("idle gating wrong");
  chk_noise_gates: assert property
    (state_q == ST_SLEEP && mode_q == MODE_ADCNR |-> !gate_q.io && !gate_q.cpu
     && gate_q.adc && gate_q.osc) // R3
    else $error("noise reduction gating wrong");
  chk_pdown_gates: assert property
    (state_q == ST_SLEEP && mode_q == MODE_PDOWN |-> !gate_q.adc && !gate_q.io
     && (gate_q.osc == debug_fuse) && !in_buf_en_q && !comp_en_q) // R4 R19 R21 R24
    else $error("power-down gating wrong");
  chk_hold_four: assert property
    (state_q == ST_WAKE && cnt_q == '0 && !rst_kind_q |=> (state_q == ST_HOLD)[*4]
     ##1 (state_q == ST_RUN && irq_resume_q)) // R5
    else $error("interrupt wake hold not four cycles");
  chk_reset_wake: assert property
    (state_q == ST_SLEEP && reset_event |=> state_q == ST_WAKE && rst_kind_q
     && cnt_q == $past(reset_cycles)) // R7
    else $error("reset during sleep not taken");
  chk_pdown_filter: assert property
    (state_q == ST_SLEEP && mode_q == MODE_PDOWN && !reset_event
     && !smc_wake_ok(MODE_PDOWN, wake_ev) |=> state_q == ST_SLEEP) // R10 R11
    else $error("power-down woke on a disallowed source");
  chk_pdown_delay: assert property
    (state_q == ST_SLEEP && mode_q == MODE_PDOWN && !reset_event && !bod_off_q
     && smc_wake_ok(MODE_PDOWN, wake_ev) |=> cnt_q == $past(startup_cycles)) // R13
    else $error("power-down wake delay not start-up time");
  chk_adc_autostart: assert property
    (state_q == ST_RUN && state_d == ST_SLEEP && mode_d != MODE_PDOWN && adc_enable
     |=> adc_start_q) // R12
    else $error("conversion not started at sleep entry");
  chk_bod_restore: assert property
    (state_q == ST_SLEEP && bod_off_q && !bod_en_q && state_d == ST_WAKE
     |=> bod_en_q == bod_fuse && cnt_q == $past(reset_cycles)) // R14 R15
    else $error("detector not restored with full wake time");

endmodule : smc_top

// >>> smc_cpu_model.sv
// cpu-side stand-in that executes the sleep instruction
`timescale 1ns/100ps
module smc_cpu_model (
  input  wire logic clk,
  output logic      sleep_instr
);
  // quiet until told; launched off the falling edge so the rising edge sees it settled
  initial sleep_instr = 1'b0;
  task automatic exec_sleep;
    @(negedge clk) sleep_instr = 1'b1;
    @(negedge clk) sleep_instr = 1'b0;
  endtask : exec_sleep
endmodule : smc_cpu_model

// >>> sleep_mode_controller_tb.sv
// self-checking bench of the sleep mode controller
`timescale 1ns/100ps
module sleep_mode_controller_tb import smc_pkg::*;;
  logic        clk = 1'b0;
  logic        resetn, sleep_wr, core_wr, reset_event, sleep_instr;
  logic [7:0]  sleep_wdata, core_wdata, sleep_ctl_rd_q, core_ctl_rd_q;
  logic        bod_fuse, adc_enable, comp_on, wdt_enable;
  logic [15:0] startup_cycles, reset_cycles;
  smc_wake_t   wk;
  smc_clk_t    gate_q;
  logic        cpu_hold_q, irq_resume_q, reset_vector_q, adc_start_q;
  logic        adc_power_q, bod_en_q, comp_en_q, wdt_run_q;
  logic        debug_fuse, retain_q, adc_extended_q, vref_en_q, in_buf_en_q, wake_buf_en_q;
  int          fails = 0, total_checks = 0, cycles = 0, starts = 0;

  smc_cpu_model cpu_u (.clk(clk), .sleep_instr(sleep_instr));
  smc_top dut_u (.clk(clk), .resetn(resetn), .sleep_wr(sleep_wr), .sleep_wdata(sleep_wdata),
    .core_wr(core_wr), .core_wdata(core_wdata), .sleep_instr(sleep_instr), .wake_ev(wk),
    .reset_event(reset_event), .startup_cycles(startup_cycles), .reset_cycles(reset_cycles),
    .bod_fuse(bod_fuse), .debug_fuse(debug_fuse), .adc_enable(adc_enable), .comp_on(comp_on),
    .comp_uses_ref(1'b0), .wdt_enable(wdt_enable), .wake_pin_armed(1'b1), .gate_q(gate_q),
    .cpu_hold_q(cpu_hold_q), .retain_q(retain_q), .irq_resume_q(irq_resume_q),
    .reset_vector_q(reset_vector_q), .adc_start_q(adc_start_q), .adc_power_q(adc_power_q),
    .adc_extended_q(adc_extended_q), .bod_en_q(bod_en_q), .comp_en_q(comp_en_q),
    .vref_en_q(vref_en_q), .wdt_run_q(wdt_run_q), .in_buf_en_q(in_buf_en_q),
    .wake_buf_en_q(wake_buf_en_q),
    .sleep_ctl_rd_q(sleep_ctl_rd_q), .core_ctl_rd_q(core_ctl_rd_q));

  initial forever #2 clk = ~clk;
  // conversion starts are one-cycle pulses, so tally them as they pass
  always @(negedge clk) if (adc_start_q === 1'b1) starts++;
  // hang guard: every scenario finishes well inside this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin fails++; conclude(); end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle register write; core selects the core control register
  task automatic wr(logic core, logic [7:0] d);
    @(negedge clk);
    if (core) begin core_wr = 1'b1; core_wdata = d; end
    else begin sleep_wr = 1'b1; sleep_wdata = d; end
    @(negedge clk);
    {core_wr, sleep_wr} = 2'b00;
  endtask : wr
  task automatic nap(logic [7:0] d);
    wr(1'b0, d);
    cpu_u.exec_sleep();
    @(negedge clk);
  endtask : nap
  // count falling edges until the resume or restart pulse, then drop the sources
  task automatic wake(int n, logic rst);
    int c = 0;
    while ((rst ? reset_vector_q : irq_resume_q) !== 1'b1 && c < 40) begin
      @(negedge clk);
      c++;
    end
    chk("wake delay", n[15:0], c[15:0]);
    wk = '0;
    reset_event = 1'b0;
  endtask : wake

  task automatic t_reserved;
    nap(8'h07);
    chk("readback", 16'h07, {8'h00, sleep_ctl_rd_q});
    chk("hold", 16'h0, {15'h0, cpu_hold_q});
  endtask : t_reserved
  task automatic t_idle;
    starts = 0;
    nap(8'h01);
    chk("gates", 16'h07, {11'h0, gate_q});
    chk("starts", 16'h1, starts[15:0]);
    wk.any_irq = 1'b1;
    wake(6, 1'b0);
  endtask : t_idle
  task automatic t_noise;
    nap(8'h03);
    chk("gates", 16'h03, {11'h0, gate_q});
    wk.ee_ready = 1'b1;
    wake(6, 1'b0);
  endtask : t_noise
  task automatic t_pdown;
    nap(8'h05);
    chk("gates", 16'h00, {11'h0, gate_q});
    chk("comparator", 16'h0, {15'h0, comp_en_q});
    chk("watchdog", 16'h1, {15'h0, wdt_run_q});
    chk("adc power", 16'h1, {15'h0, adc_power_q});
    chk("buffers", 16'h1, {14'h0, in_buf_en_q, wake_buf_en_q});
    chk("retain", 16'h1, {15'h0, retain_q});
    chk("vref", 16'h1, {15'h0, vref_en_q});
    chk("adc extended", 16'h1, {15'h0, adc_extended_q});
    wk.ext_a = 1'b1;
    repeat (6) @(negedge clk);
    chk("hold", 16'h1, {15'h0, cpu_hold_q});
    wk.ext_a_level = 1'b1;
    wake(9, 1'b0);
  endtask : t_pdown
  task automatic t_reset;
    debug_fuse = 1'b1;
    nap(8'h05);
    chk("gates", 16'h01, {11'h0, gate_q});
    reset_event = 1'b1;
    wake(4, 1'b1);
    debug_fuse = 1'b0;
  endtask : t_reset
  // unlock then set, and sleep while the sleep-off bit is active
  task automatic t_brownout_sleep_off;
    wr(1'b0, 8'h05);
    wr(1'b1, 8'h40);
    wr(1'b1, 8'h60);
    chk("core reg", 16'h00, {8'h00, core_ctl_rd_q});
    wr(1'b1, 8'h40);
    @(negedge clk);
    chk("core reg", 16'h40, {8'h00, core_ctl_rd_q});
    @(negedge clk);
    cpu_u.exec_sleep();
    @(negedge clk);
    chk("detector", 16'h0, {15'h0, bod_en_q});
    wk.pin_change = 1'b1;
    wake(8, 1'b0);
    chk("detector", 16'h1, {15'h0, bod_en_q});
  endtask : t_brownout_sleep_off

  initial begin
    resetn = 1'b0;
    {sleep_wr, core_wr, reset_event} = 3'b000;
    sleep_wdata = 8'h00;
    core_wdata = 8'h00;
    wk = '0;
    {bod_fuse, adc_enable, comp_on, wdt_enable} = 4'hF;
    debug_fuse = 1'b0;
    startup_cycles = 16'h0003;
    reset_cycles = 16'h0002;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    chk("core reg", 16'h0, {8'h00, core_ctl_rd_q});
    t_reserved();
    t_idle();
    t_noise();
    t_pdown();
    t_reset();
    t_brownout_sleep_off();
    conclude();
  end
endmodule : sleep_mode_controller_tb
